// file: include/swirq_defines.vh
// Purpose: Register map and field layout of the switch-input edge selection banks.
// Assumes: 8-bit register address, 24-bit register data.
// Notes:   Each input field holds one 2-bit edge selector per threshold, low pair first.
`ifndef SWIRQ_DEFINES_VH
`define SWIRQ_DEFINES_VH

// ----------------------------------------------------------------------
// Register offsets and reset values
// ----------------------------------------------------------------------
`define SWIRQ_OFS_BANK2      8'h26
`define SWIRQ_OFS_BANK3      8'h27
`define SWIRQ_RST_BANK2      24'h000000
`define SWIRQ_RST_BANK3      24'h000000
`define SWIRQ_RDATA_UNMAPPED 24'h000000

// ----------------------------------------------------------------------
// Field positions (least significant bit of each field)
// ----------------------------------------------------------------------
`define SWIRQ_IN12_LSB       0
`define SWIRQ_IN13_LSB       4
`define SWIRQ_IN14_LSB       8
`define SWIRQ_IN18_LSB       0
`define SWIRQ_IN19_LSB       6
`define SWIRQ_IN20_LSB       12
`define SWIRQ_IN21_LSB       18
`define SWIRQ_TWO_LVL_BITS   12
`define SWIRQ_TWO_LVL_THR    2
`define SWIRQ_THREE_LVL_THR  3

// ----------------------------------------------------------------------
// Edge selector encoding
// ----------------------------------------------------------------------
`define SWIRQ_EDGE_NONE      2'h0
`define SWIRQ_EDGE_RISE      2'h1
`define SWIRQ_EDGE_FALL      2'h2
`define SWIRQ_EDGE_BOTH      2'h3

`endif

// file: src/swirq_sync.v
// Purpose: Two-stage synchroniser for asynchronous comparator levels.
// Assumes: Inputs are quasi-static levels, not pulses.
// Notes:   First stage feeds only the second stage.
`timescale 1ns/100ps

module swirq_sync #(
	parameter WIDTH = 1
) (
	input  wire             mclk,
	input  wire             rstn,
	input  wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);

	reg [WIDTH-1:0] meta_ff;
	reg [WIDTH-1:0] stable_ff;

	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			meta_ff   <= {WIDTH{1'b0}};
			stable_ff <= {WIDTH{1'b0}};
		end else begin
			meta_ff   <= async_in;
			stable_ff <= meta_ff;
		end
	end

	assign sync_out = stable_ff;

endmodule // swirq_sync

// file: src/swirq_edge_cell.v
// Purpose: Crossing detector for one input against one threshold.
// Assumes: sample_stb marks a fresh comparator result on level.
// Notes:   The first sample after reset only primes the history.
`timescale 1ns/100ps
`include "swirq_defines.vh"

module swirq_edge_cell (
	input  wire       mclk,
	input  wire       rstn,
	input  wire       sample_stb,
	input  wire       level,
	input  wire [1:0] edge_sel,
	output wire       hit
);

	reg prev_ff;
	reg primed_ff;

	wire rose;
	wire fell;

	// No history yet after reset, so no crossing can be claimed
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			prev_ff   <= 1'b0;
			primed_ff <= 1'b0;
		end else if (sample_stb) begin
			prev_ff   <= level;
			primed_ff <= 1'b1;
		end
	end

	assign rose = ~prev_ff & level;
	assign fell = prev_ff & ~level;

	// Bit 0 of the selector enables rising, bit 1 falling; 11 gives both
	assign hit = sample_stb & primed_ff &
		((rose & edge_sel[0]) | (fell & edge_sel[1]));

endmodule // swirq_edge_cell

// file: src/swirq_edge_cfg.v
// Purpose: Edge selection banks and crossing interrupts for switch inputs 12-14 and 18-21.
// Assumes: Comparator levels arrive asynchronously; sample_stb is on mclk.
// Notes:   Bank 2 bits 23-12 are stored and read back but steer nothing here.
//
// What this block does
// - Input 14 bits 9-8 choose none/rise/fall/both against two-level threshold A.
// - Input 14 bits 11-10 choose none/rise/fall/both against two-level threshold B.
// - Input 13 field is bits 7-4: low pair threshold A, high pair B.
// - Input 12 field is bits 3-0; pair value zero disables that threshold.
// - Bank 3 is at offset 27h and resets to zero, all disabled.
// - Input 21 field bits 23-18; lowest pair selects three-level threshold A edges.
// - Input 21 middle pair selects three-level threshold B edges independently.
// - Input 21 top pair selects threshold C edges; 11 means both.
// - Input 20 field bits 17-12; pairs A, B, C from low to high.
// - Input 19 field bits 11-6; pairs for thresholds A, B, C.
// - Input 18 field bits 5-0; same three-pair encoding.
`timescale 1ns/100ps
`include "swirq_defines.vh"

module swirq_edge_cfg (
	input  wire        mclk,
	input  wire        rstn,
	input  wire [7:0]  reg_addr,
	input  wire        reg_wr,
	input  wire [23:0] reg_wdata,
	input  wire        reg_rd,
	output reg  [23:0] reg_rdata_ff,
	output reg         reg_rvalid_ff,
	input  wire        sample_stb,
	input  wire [5:0]  two_lvl_above,
	input  wire [11:0] three_lvl_above,
	output reg  [2:0]  two_lvl_irq_ff,
	output reg  [3:0]  three_lvl_irq_ff,
	output reg         irq_any_ff
);

	// ------------------------------------------------------------------
	// Register storage
	// ------------------------------------------------------------------
	reg  [23:0] bank2_ff;
	reg  [23:0] bank3_ff;
	reg  [23:0] nxt_rdata;
	reg         sample_d1_ff;
	reg         sample_d2_ff;

	wire        wr_bank2;
	wire        wr_bank3;
	wire [5:0]  two_lvl_sync;
	wire [11:0] three_lvl_sync;
	wire [5:0]  two_lvl_hit;
	wire [11:0] three_lvl_hit;
	wire [2:0]  nxt_two_lvl_irq;
	wire [3:0]  nxt_three_lvl_irq;
	wire [3:0]  input12_irq_edges;
	wire [3:0]  input13_irq_edges;
	wire [3:0]  input14_irq_edges;
	wire [5:0]  input18_irq_edges;
	wire [5:0]  input19_irq_edges;
	wire [5:0]  input20_irq_edges;
	wire [5:0]  input21_irq_edges;
	wire [23:0] two_lvl_sel;
	wire [23:0] three_lvl_sel;

	// Pick the 2-bit selector for one threshold out of a bank
	function [1:0] pair_sel;
		input [23:0] bank;
		input integer idx;
		begin
			pair_sel = bank[idx * 2 +: 2];
		end
	endfunction

	assign wr_bank2 = reg_wr & (reg_addr == `SWIRQ_OFS_BANK2);
	assign wr_bank3 = reg_wr & (reg_addr == `SWIRQ_OFS_BANK3);

	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			bank2_ff <= `SWIRQ_RST_BANK2;
			bank3_ff <= `SWIRQ_RST_BANK3;
		end else begin
			if (wr_bank2) begin
				bank2_ff <= reg_wdata;
			end
			if (wr_bank3) begin
				bank3_ff <= reg_wdata;
			end
		end
	end

	// ------------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------------
	// Read samples the stored value before a same-cycle write lands
	always @* begin
		case (reg_addr)
			`SWIRQ_OFS_BANK2: begin
				nxt_rdata = bank2_ff;
			end
			`SWIRQ_OFS_BANK3: begin
				nxt_rdata = bank3_ff;
			end
			default: begin
				nxt_rdata = `SWIRQ_RDATA_UNMAPPED;
			end
		endcase
	end

	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata_ff  <= 24'h000000;
			reg_rvalid_ff <= 1'b0;
		end else begin
			reg_rvalid_ff <= reg_rd;
			if (reg_rd) begin
				reg_rdata_ff <= nxt_rdata;
			end
		end
	end

	// ------------------------------------------------------------------
	// Field decode
	// ------------------------------------------------------------------
	// Bank 2 upper fields belong to inputs outside this block and stay unused
	assign input12_irq_edges = bank2_ff[`SWIRQ_IN12_LSB +: 4];
	assign input13_irq_edges = bank2_ff[`SWIRQ_IN13_LSB +: 4];
	assign input14_irq_edges = bank2_ff[`SWIRQ_IN14_LSB +: 4];
	assign input18_irq_edges = bank3_ff[`SWIRQ_IN18_LSB +: 6];
	assign input19_irq_edges = bank3_ff[`SWIRQ_IN19_LSB +: 6];
	assign input20_irq_edges = bank3_ff[`SWIRQ_IN20_LSB +: 6];
	assign input21_irq_edges = bank3_ff[`SWIRQ_IN21_LSB +: 6];

	// Pair k of these vectors is the selector for level bit k
	assign two_lvl_sel   = {12'h000, input14_irq_edges,
		input13_irq_edges, input12_irq_edges};
	assign three_lvl_sel = {input21_irq_edges, input20_irq_edges,
		input19_irq_edges, input18_irq_edges};

	// ------------------------------------------------------------------
	// Comparator level synchronisation
	// ------------------------------------------------------------------
	swirq_sync #(
		.WIDTH(6)
	) u_sync_two (
		.mclk     (mclk),
		.rstn     (rstn),
		.async_in (two_lvl_above),
		.sync_out (two_lvl_sync)
	);

	swirq_sync #(
		.WIDTH(12)
	) u_sync_three (
		.mclk     (mclk),
		.rstn     (rstn),
		.async_in (three_lvl_above),
		.sync_out (three_lvl_sync)
	);

	// The strobe is delayed to line up with the two-stage level path
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			sample_d1_ff <= 1'b0;
			sample_d2_ff <= 1'b0;
		end else begin
			sample_d1_ff <= sample_stb;
			sample_d2_ff <= sample_d1_ff;
		end
	end

	// ------------------------------------------------------------------
	// Crossing detectors
	// ------------------------------------------------------------------
	// Two-level inputs 12,13,14: pair k of bank 2 low bits, A then B
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi = gi + 1) begin : g_two
			swirq_edge_cell u_cell (
				.mclk       (mclk),
				.rstn       (rstn),
				.sample_stb (sample_d2_ff),
				.level      (two_lvl_sync[gi]),
				.edge_sel   (pair_sel(two_lvl_sel, gi)),
				.hit        (two_lvl_hit[gi])
			);
		end
		// Three-level inputs 18..21: pair k of bank 3, A, B, C per input
		for (gi = 0; gi < 12; gi = gi + 1) begin : g_three
			swirq_edge_cell u_cell (
				.mclk       (mclk),
				.rstn       (rstn),
				.sample_stb (sample_d2_ff),
				.level      (three_lvl_sync[gi]),
				.edge_sel   (pair_sel(three_lvl_sel, gi)),
				.hit        (three_lvl_hit[gi])
			);
		end
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_two_or
			assign nxt_two_lvl_irq[gi] = |two_lvl_hit[gi * 2 +: 2];
		end
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_three_or
			assign nxt_three_lvl_irq[gi] = |three_lvl_hit[gi * 3 +: 3];
		end
	endgenerate

	// ------------------------------------------------------------------
	// Interrupt outputs
	// ------------------------------------------------------------------
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			two_lvl_irq_ff   <= 3'h0;
			three_lvl_irq_ff <= 4'h0;
			irq_any_ff       <= 1'b0;
		end else begin
			two_lvl_irq_ff   <= nxt_two_lvl_irq;
			three_lvl_irq_ff <= nxt_three_lvl_irq;
			irq_any_ff       <= (|nxt_two_lvl_irq) | (|nxt_three_lvl_irq);
		end
	end

endmodule // swirq_edge_cfg

// file: bench/swirq_edge_cfg_asserts.sv
// Purpose: Port checks for swirq_edge_cfg.
// Assumes: One clock domain.
// Notes:   Events lag the strobe by three edges.
`timescale 1ns/100ps
module swirq_edge_cfg_asserts (
	input logic        mclk,
	input logic        rstn,
	input logic [7:0]  reg_addr,
	input logic        reg_wr,
	input logic [23:0] reg_wdata,
	input logic        reg_rd,
	input logic [23:0] reg_rdata_ff,
	input logic        reg_rvalid_ff,
	input logic        sample_stb,
	input logic [2:0]  two_lvl_irq_ff,
	input logic [3:0]  three_lvl_irq_ff,
	input logic        irq_any_ff
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	a_read_answer: assert property (reg_rd |=> reg_rvalid_ff) else $error("no rvalid");
	a_rdata_hold: assert property (!reg_rd |=> !reg_rvalid_ff && $stable(reg_rdata_ff))
		else $error("rdata moved");
	a_write_back: assert property (reg_wr && reg_addr == 8'h27 ##1
		reg_rd && !reg_wr && reg_addr == 8'h27 |=> reg_rdata_ff == $past(reg_wdata, 2))
		else $error("readback");
	a_unmapped_zero: assert property (reg_rd && reg_addr != 8'h26 && reg_addr != 8'h27
		|=> reg_rdata_ff == 24'h000000) else $error("unmapped");
	a_two_cause: assert property (|two_lvl_irq_ff |-> $past(sample_stb, 3))
		else $error("two event");
	a_three_cause: assert property (|three_lvl_irq_ff |-> $past(sample_stb, 3))
		else $error("three event");
	a_any_or: assert property (irq_any_ff == |{two_lvl_irq_ff, three_lvl_irq_ff})
		else $error("any");
	a_reset_quiet: assert property ($rose(rstn) |-> !irq_any_ff && !reg_rvalid_ff)
		else $error("reset");
endmodule // swirq_edge_cfg_asserts

// file: bench/swirq_sw_model.sv
// Purpose: Switch comparators facing the block.
// Assumes: Bench sets wanted levels.
// Notes:   Levels move on the falling edge, clear of sampling.
`timescale 1ns/100ps
module swirq_sw_model (
	input  logic        mclk,
	input  logic [17:0] want_lvl,
	output logic [5:0]  two_lvl_above,
	output logic [11:0] three_lvl_above
);
	always @(negedge mclk) {three_lvl_above, two_lvl_above} <= want_lvl;
endmodule // swirq_sw_model

// file: bench/swirq_edge_cfg_test.sv
// Purpose: Self-checking bench for swirq_edge_cfg.
// Assumes: Falling-edge drive, LFSR seed 45.
// Notes:   Strobes stay up between like requests.
`timescale 1ns/100ps
module swirq_edge_cfg_test;
	logic        mclk = 1'b0;
	logic        rstn = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic        reg_wr = 1'b0;
	logic [23:0] reg_wdata = 24'h000000;
	logic        reg_rd = 1'b0;
	logic        sample_stb = 1'b0;
	logic [17:0] want_lvl = 18'h00000;
	logic [17:0] prev_lvl;
	logic [23:0] b2;
	logic [23:0] b3;
	logic [23:0] lfsr_ff = 24'h00002D;
	logic [23:0] reg_rdata_ff;
	logic        reg_rvalid_ff;
	logic [5:0]  two_lvl_above;
	logic [11:0] three_lvl_above;
	logic [2:0]  two_lvl_irq_ff;
	logic [3:0]  three_lvl_irq_ff;
	logic        irq_any_ff;
	int          failures = 0;
	int          compares = 0;
	int          cycles = 0;
	always #5 mclk = ~mclk;
	swirq_sw_model u_sw (.mclk(mclk), .want_lvl(want_lvl), .two_lvl_above(two_lvl_above),
		.three_lvl_above(three_lvl_above));
	swirq_edge_cfg u_dut (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
		.reg_rvalid_ff(reg_rvalid_ff), .sample_stb(sample_stb), .two_lvl_above(two_lvl_above),
		.three_lvl_above(three_lvl_above), .two_lvl_irq_ff(two_lvl_irq_ff),
		.three_lvl_irq_ff(three_lvl_irq_ff), .irq_any_ff(irq_any_ff));
	function automatic logic [23:0] rnd();
		repeat (24) lfsr_ff = {lfsr_ff[22:0], ^{lfsr_ff[23:21], lfsr_ff[16]}};
		return lfsr_ff;
	endfunction
	function automatic logic hit(input logic [1:0] s, input logic p, input logic c);
		return (s[0] & !p & c) | (s[1] & p & !c);
	endfunction
	function automatic logic [7:0] exp_ev(input logic [17:0] p, input logic [17:0] c);
		exp_ev = 8'h00;
		for (int k = 0; k < 6; k++)
			exp_ev[k / 2] |= hit(b2[2 * k +: 2], p[k], c[k]);
		for (int k = 0; k < 12; k++)
			exp_ev[3 + k / 3] |= hit(b3[2 * k +: 2], p[6 + k], c[6 + k]);
		exp_ev[7] = |exp_ev[6:0];
	endfunction
	task automatic chk_reg(input logic [24:0] got, input logic [24:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t read %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_irq(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t events %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [23:0] d);
		reg_rd = 1'b0;
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge mclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [23:0] e);
		reg_wr = 1'b0;
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge mclk);
		chk_reg({reg_rvalid_ff, reg_rdata_ff}, {1'b1, e});
	endtask
	// Events stand from the second rising edge after the strobe edge, for one cycle
	task automatic sample(input logic [17:0] lvl, input logic prime);
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		want_lvl = lvl;
		repeat (4) @(negedge mclk);
		sample_stb = 1'b1;
		@(negedge mclk);
		sample_stb = 1'b0;
		repeat (2) @(negedge mclk);
		chk_irq({irq_any_ff, three_lvl_irq_ff, two_lvl_irq_ff},
			prime ? 8'h00 : exp_ev(prev_lvl, lvl));
		prev_lvl = lvl;
	endtask
	task automatic end_of_test();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			$display("[ERR] %0t timeout", $time);
			end_of_test();
		end
	end
	initial begin
		repeat (12) @(negedge mclk);
		rstn = 1'b1;
		rd(8'h26, 24'h000000);
		rd(8'h27, 24'h000000);
		b2 = 24'hFFFFFF;
		b3 = 24'hFFFFFF;
		wr(8'h26, b2);
		wr(8'h27, b3);
		sample(18'h3FFFF, 1'b1);
		$display("reset test done");
		for (int i = 0; i < 40; i++) begin
			b2 = i == 0 ? 24'hFFFFFF : i == 1 ? 24'h000000 : rnd();
			b3 = i == 0 ? 24'hFFFFFF : i == 1 ? 24'h000000 : rnd();
			wr(8'h26, b2);
			wr(8'h27, b3);
			rd(8'h27, b3);
			rd(8'h26, b2);
			rd(8'h28, 24'h000000);
			sample(i == 0 ? 18'h00000 : i == 1 ? 18'h3FFFF : 18'(rnd()), 1'b0);
			$display("edge test %0d done", i);
		end
		end_of_test();
	end
endmodule // swirq_edge_cfg_test
bind swirq_edge_cfg swirq_edge_cfg_asserts u_chk (.mclk(mclk), .rstn(rstn),
	.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
	.reg_rdata_ff(reg_rdata_ff), .reg_rvalid_ff(reg_rvalid_ff), .sample_stb(sample_stb),
	.two_lvl_irq_ff(two_lvl_irq_ff), .three_lvl_irq_ff(three_lvl_irq_ff),
	.irq_any_ff(irq_any_ff));
